// ### rtl/otp_ctrl.sv
// controller that reads, programs, verifies and identifies the memory
`timescale 1ns/1ps
module otp_ctrl
   import otp_pkg::*;
#(
   parameter int PULSE_CYCLES = otp_pkg::PULSE_CYC,
   parameter int SETUP_CYCLES = otp_pkg::SETUP_CYC,
   parameter int ACC_CYCLES   = otp_pkg::ACCESS_CYC,
   parameter int PULSE_LIMIT  = otp_pkg::MAX_PULSES
) (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      nrst,
   // request side
   input  wire logic                      req_valid,
   input  wire otp_pkg::otp_req_s         req,
   output logic                           req_ready,
   output logic                           done,
   output logic                           fail,
   output logic [otp_pkg::ADDR_W-1:0]     fail_addr,
   output logic [otp_pkg::DATA_W-1:0]     rd_data,
   output logic                           rd_valid,
   // device pins
   output otp_pkg::otp_pins_s             pins,
   input  wire logic [otp_pkg::DATA_W-1:0] data_lines_in,
   output logic [otp_pkg::DATA_W-1:0]     data_lines_out,
   output logic                           data_lines_oe
);
   import otp_pkg::*;

   initial begin
      if (PULSE_CYCLES < 1 || PULSE_CYCLES >= (1 << 24) ||
          SETUP_CYCLES < 1 || SETUP_CYCLES >= (1 << 24) ||
          ACC_CYCLES < 1 || ACC_CYCLES >= (1 << 24) ||
          PULSE_LIMIT < 1 || PULSE_LIMIT > 255)
         $error("otp_ctrl: unsupported parameter value");
   end

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP  = 3'b001,
      ST_PULSE  = 3'b010,
      ST_VSET   = 3'b011,
      ST_SAMPLE = 3'b100,
      ST_DONE   = 3'b101
   } otp_st_e;

   otp_st_e           st;
   otp_cmd_e          cmd;
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] first;
   logic [ADDR_W-1:0] last;
   logic [DATA_W-1:0] wdata;
   logic [23:0]       cnt;
   logic [7:0]        pulses;
   logic              final_pass;
   logic [DATA_W-1:0] din_meta;
   logic [DATA_W-1:0] din;

   // pins from outside pass two flops before use
   always_ff @(posedge clock) begin
      din_meta <= data_lines_in;
      din      <= din_meta;
   end

   assign req_ready = (st == ST_IDLE);

   // sampling waits for setup and access delay plus the two sync flops
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st         <= ST_IDLE;
         cmd        <= OTP_CMD_READ;
         addr       <= ADDR_RST;
         first      <= ADDR_RST;
         last       <= ADDR_RST;
         wdata      <= '0;
         cnt        <= '0;
         pulses     <= '0;
         final_pass <= 1'b0;
         done       <= 1'b0;
         fail       <= 1'b0;
         fail_addr  <= ADDR_RST;
         rd_data    <= '0;
         rd_valid   <= 1'b0;
      end else begin
         done     <= 1'b0;
         rd_valid <= 1'b0;
         unique case (st)
            ST_IDLE: begin
               if (req_valid) begin
                  cmd        <= req.cmd;
                  addr       <= req.first;
                  first      <= req.first;
                  last       <= req.last;
                  wdata      <= req.data;
                  pulses     <= '0;
                  final_pass <= 1'b0;
                  fail       <= 1'b0;
                  cnt        <= '0;
                  st         <= (req.cmd == OTP_CMD_PROG) ? ST_SETUP
                                                          : ST_VSET;
               end
            end
            ST_SETUP: begin
               cnt <= cnt + 24'h000001;
               if (cnt == 24'(SETUP_CYCLES - 1)) begin
                  cnt <= '0;
                  st  <= ST_PULSE;
               end
            end
            ST_PULSE: begin
               cnt <= cnt + 24'h000001;
               if (cnt == 24'(PULSE_CYCLES - 1)) begin
                  cnt    <= '0;
                  pulses <= pulses + 8'h01;
                  st     <= ST_VSET;
               end
            end
            ST_VSET: begin
               cnt <= cnt + 24'h000001;
               if (cnt == 24'(SETUP_CYCLES + ACC_CYCLES + 1)) begin
                  cnt <= '0;
                  st  <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               rd_data  <= din;
               rd_valid <= 1'b1;
               if (cmd == OTP_CMD_PROG && !final_pass) begin
                  if (din == wdata) begin
                     pulses <= '0;
                     if (addr == last) begin
                        final_pass <= 1'b1;
                        addr       <= last;
                        st         <= ST_DONE;
                     end else begin
                        addr <= addr + 15'h0001;
                        st   <= ST_SETUP;
                     end
                  end else if (pulses < 8'(PULSE_LIMIT)) begin
                     st <= ST_SETUP;
                  end else begin
                     fail      <= 1'b1;
                     fail_addr <= addr;
                     done      <= 1'b1;
                     st        <= ST_IDLE;
                  end
               end else if (cmd == OTP_CMD_PROG && din != wdata) begin
                  fail      <= 1'b1;
                  fail_addr <= addr;
                  done      <= 1'b1;
                  st        <= ST_IDLE;
               end else if (addr == last || cmd == OTP_CMD_ID) begin
                  done <= 1'b1;
                  st   <= ST_IDLE;
               end else begin
                  addr <= addr + 15'h0001;
                  st   <= ST_VSET;
               end
            end
            ST_DONE: begin
               // read-back restarts at the held first address, req may move
               addr <= first;
               cnt  <= '0;
               st   <= ST_VSET;
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   // pin decode from state
   always_comb begin
      pins.addr_lines      = addr;
      pins.sel_n           = 1'b1;
      pins.gate_n          = 1'b1;
      pins.prog_supply     = 1'b0;
      pins.core_raise      = 1'b0;
      pins.id_high_voltage = 1'b0;
      data_lines_out       = wdata;
      data_lines_oe        = 1'b0;
      if (cmd == OTP_CMD_PROG && !final_pass && st != ST_IDLE) begin
         pins.prog_supply = 1'b1;
         pins.core_raise  = 1'b1;
         if (st == ST_SETUP || st == ST_PULSE) begin
            data_lines_oe = 1'b1;
            pins.sel_n    = (st != ST_PULSE);
         end else begin
            pins.sel_n  = 1'b0;
            pins.gate_n = 1'b0;
         end
      end else if (st == ST_VSET || st == ST_SAMPLE) begin
         pins.sel_n  = 1'b0;
         pins.gate_n = 1'b0;
         if (cmd == OTP_CMD_VER) begin
            pins.prog_supply = 1'b1;
            pins.core_raise  = 1'b1;
         end
         if (cmd == OTP_CMD_ID) begin
            pins.addr_lines      = {14'h0000, addr[0]};
            pins.id_high_voltage = 1'b1;
         end
      end
   end
endmodule

// ### rtl/otp_pkg.sv
// package: constants and carrier types for the one-time memory programmer
package otp_pkg;
   localparam int ADDR_W        = 15;
   localparam int DATA_W        = 8;
   localparam int CLK_MHZ       = 125;
   localparam int PULSE_NOM_US  = 100;
   localparam int PULSE_MIN_US  = 95;
   localparam int PULSE_MAX_US  = 105;
   localparam int PULSE_CYC     = PULSE_NOM_US * CLK_MHZ;
   localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
   localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
   localparam int MAX_PULSES    = 25;
   localparam int SETUP_US      = 2;
   localparam int SETUP_CYC     = SETUP_US * CLK_MHZ;
   localparam int ACCESS_NS     = 250;
   localparam int ACCESS_CYC    = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int ID_BIT        = 9;
   localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;

   typedef enum logic [1:0] {
      OTP_CMD_READ = 2'b00,
      OTP_CMD_PROG = 2'b01,
      OTP_CMD_VER  = 2'b10,
      OTP_CMD_ID   = 2'b11
   } otp_cmd_e;

   // device pin bundle driven by the controller
   typedef struct packed {
      logic [ADDR_W-1:0] addr_lines;
      logic              sel_n;
      logic              gate_n;
      logic              prog_supply;
      logic              core_raise;
      logic              id_high_voltage;
   } otp_pins_s;

   typedef struct packed {
      otp_cmd_e          cmd;
      logic [ADDR_W-1:0] first;
      logic [ADDR_W-1:0] last;
      logic [DATA_W-1:0] data;
   } otp_req_s;
endpackage

// ### tb/otp_ctrl_properties.sv
// checker: pin-level properties of the programmer
`timescale 1ns/1ps
module otp_ctrl_chk
   import otp_pkg::*;
#(
   parameter int PULSE_CYCLES = 20,
   parameter int SETUP_CYCLES = 2
) (
   // clock and reset
   input wire logic                       clock,
   input wire logic                       nrst,
   // watched outputs
   input wire logic                       req_ready,
   input wire logic                       done,
   input wire logic                       fail,
   input wire otp_pkg::otp_pins_s         pins,
   input wire logic [otp_pkg::DATA_W-1:0] data_lines_out,
   input wire logic                       data_lines_oe
);
   logic pon;
   int   pcnt;
   assign pon = !pins.sel_n && pins.gate_n && data_lines_oe;
   // width counted here, an exact figure beats a window
   always_ff @(posedge clock) begin
      if (!nrst || !pon)
         pcnt <= 0;
      else
         pcnt <= pcnt + 1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence pulse_end_s;
      $past(pon) && !pon;
   endsequence
   sequence pulse_hold_s;
      $past(pon) && pon;
   endsequence
   pulse_width_a: assert property (pulse_end_s |-> pcnt == PULSE_CYCLES)
      else $error("pulse width wrong");
   pulse_setup_a: assert property ($rose(pon) |->
      $past(data_lines_oe, SETUP_CYCLES) && $past(pins.prog_supply, SETUP_CYCLES))
      else $error("pulse setup short");
   pulse_supply_a: assert property (pon |->
      pins.prog_supply && pins.core_raise && !pins.id_high_voltage)
      else $error("pulse without supplies");
   pulse_stable_a: assert property (pulse_hold_s |->
      $stable(data_lines_out) && $stable(pins.addr_lines))
      else $error("lines moved in pulse");
   oe_gate_a: assert property (data_lines_oe |-> pins.gate_n)
      else $error("drive while gated");
   id_lines_a: assert property (pins.id_high_voltage |->
      (pins.addr_lines & 15'h7dfe) == 15'h0000)
      else $error("id address not low");
   idle_quiet_a: assert property (req_ready |-> pins.sel_n && !data_lines_oe)
      else $error("idle not deselected");
   fail_done_a: assert property ($rose(fail) |-> done)
      else $error("fail without done");
endmodule

// ### tb/otp_dev_model.sv
// partner: behavioural one-time memory seen at its pins
`timescale 1ns/1ps
module otp_dev_model
   import otp_pkg::*;
#(
   parameter logic [7:0] MAKER = 8'h8a, // arbitrary value
   parameter logic [7:0] PART  = 8'h07, // arbitrary value
   parameter int         ACC   = 2
) (
   // pins
   input  wire logic                       clock,
   input  wire otp_pkg::otp_pins_s         pins,
   input  wire logic [otp_pkg::DATA_W-1:0] dq,
   output logic [otp_pkg::DATA_W-1:0]      q
);
   logic [7:0]        mem [0:(1<<ADDR_W)-1];
   logic [7:0]        last = 8'h00;
   logic [7:0]        pdata, val;
   logic [ADDR_W-1:0] paddr;
   logic              pon, drive, ok;
   logic              pon_q = 1'b0;
   logic [7:0]        acc_cnt = 8'h00;
   logic [ADDR_W-1:0] addr_q = '0;
   int                pulses = 0;
   int                vsup = 0;
   initial foreach (mem[i]) mem[i] = 8'hff;
   // pulse only with gate high, supplies up
   assign pon = !pins.sel_n && pins.gate_n && pins.prog_supply &&
                pins.core_raise;
   assign drive = !pins.sel_n && !pins.gate_n;
   assign val = !pins.id_high_voltage ? mem[pins.addr_lines] :
                pins.addr_lines[0] ? PART : MAKER;
   // data valid one access delay after select, gate or address
   assign ok = drive && acc_cnt == 8'(ACC);
   // released or settling lines show the inverse of the last valid byte
   assign q = ok ? val : ~last;
   always @(posedge clock) begin
      pon_q  <= pon;
      addr_q <= pins.addr_lines;
      if (!drive || pins.addr_lines !== addr_q)
         acc_cnt <= 8'h00;
      else if (acc_cnt < 8'(ACC))
         acc_cnt <= acc_cnt + 8'h01;
      if (drive && pins.prog_supply)
         vsup <= vsup + 1;
      if (ok)
         last <= val;
      if (pon) begin
         pdata <= dq;
         paddr <= pins.addr_lines;
      end
      // only ones clear, at pulse end
      if (pon_q && !pon) begin
         mem[paddr] <= mem[paddr] & pdata;
         pulses <= pulses + 1;
      end
   end
endmodule

// ### tb/tb_otp_ctrl.sv
// testbench: programmer against a device model
`timescale 1ns/1ps
module tb_otp_ctrl;
   import otp_pkg::*;
   localparam logic [7:0] MAKER = 8'h8a; // arbitrary, odd parity
   localparam logic [7:0] PART  = 8'h07; // arbitrary, odd parity
   logic              clock = 0, nrst = 0, req_valid = 0;
   otp_req_s          req = '0;
   logic              req_ready, done, fail, rd_valid, data_lines_oe;
   logic [ADDR_W-1:0] fail_addr;
   logic [7:0]        rd_data, data_lines_out, dev_q, data_lines_in;
   otp_pins_s         pins;
   int                fail_count = 0, check_count = 0, nrd, p;
   always #4 clock = ~clock;
   assign data_lines_in = data_lines_oe ? data_lines_out : dev_q;
   otp_ctrl #(.PULSE_CYCLES(20), .SETUP_CYCLES(2), .ACC_CYCLES(2),
      .PULSE_LIMIT(MAX_PULSES)) DUT (.clock, .nrst, .req_valid, .req,
      .req_ready, .done, .fail, .fail_addr, .rd_data, .rd_valid, .pins,
      .data_lines_in, .data_lines_out, .data_lines_oe);
   otp_dev_model #(.MAKER(MAKER), .PART(PART), .ACC(2)) DEV (.clock, .pins,
      .dq(data_lines_in), .q(dev_q));
   task automatic check(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic op(input otp_cmd_e c, input logic [14:0] f, l,
                     input logic [7:0] d, exp);
      int n;
      nrd = 0;
      @(posedge clock);
      #1 req_valid = 1;
      req = '{c, f, l, d};
      @(posedge clock);
      #1 req_valid = 0;
      for (n = 0; n < 5000; n++) begin
         if (rd_valid === 1'b1 && c != OTP_CMD_PROG) begin
            nrd++;
            check("rd_data", rd_data, exp);
         end
         if (done === 1'b1)
            break;
         @(posedge clock);
         #1;
      end
      if (n == 5000) begin
         fail_count++;
         tally_and_finish();
      end
   endtask
   task automatic t_blank();
      op(OTP_CMD_READ, 15'h0000, 15'h0001, 8'h00, 8'hff);
      check("blank count", 16'(nrd), 16'h0002);
   endtask
   task automatic t_prog();
      p = DEV.pulses;
      op(OTP_CMD_PROG, 15'h0003, 15'h0005, 8'ha5, 8'h00);
      check("prog fail", fail, 1'b0);
      check("pulses", 16'(DEV.pulses - p), 16'h0003);
      op(OTP_CMD_READ, 15'h0003, 15'h0005, 8'h00, 8'ha5);
      check("read count", 16'(nrd), 16'h0003);
      p = DEV.vsup;
      op(OTP_CMD_VER, 15'h0004, 15'h0004, 8'h00, 8'ha5);
      check("verify count", 16'(nrd), 16'h0001);
      check("verify supply", 16'(DEV.vsup > p), 16'h0001);
   endtask
   task automatic t_retry();
      p = DEV.pulses;
      op(OTP_CMD_PROG, 15'h0004, 15'h0004, 8'h5a, 8'h00);
      check("fail", fail, 1'b1);
      check("fail addr", 16'(fail_addr), 16'h0004);
      check("retries", 16'(DEV.pulses - p), 16'(MAX_PULSES));
   endtask
   task automatic t_id();
      op(OTP_CMD_ID, 15'h0000, 15'h0000, 8'h00, MAKER);
      check("parity", ^rd_data, 1'b1);
      op(OTP_CMD_ID, 15'h0001, 15'h0001, 8'h00, PART);
      check("id count", 16'(nrd), 16'h0001);
   endtask
   initial begin
      repeat (8) @(posedge clock);
      #1 nrst = 1;
      t_blank();
      t_prog();
      t_retry();
      t_id();
      tally_and_finish();
   end
endmodule
bind otp_ctrl otp_ctrl_chk #(.PULSE_CYCLES(PULSE_CYCLES),
   .SETUP_CYCLES(SETUP_CYCLES)) CHK (.clock, .nrst, .req_ready, .done,
   .fail, .pins, .data_lines_out, .data_lines_oe);
